/* File: logic/hcd_defines.svh */
// hcd_defines.svh: offsets, field positions, reset values and timing counts
// assumes: included by bare name from the hub config register bank files
`ifndef HCD_DEFINES_SVH
`define HCD_DEFINES_SVH

// register offsets on the management port
`define HCD_OFS_CHARGE_CTRL 8'hf2
`define HCD_OFS_STATUS_CMD 8'hf8
// charge port control fields
`define HCD_CHG_RSVD0_BIT 0
`define HCD_CHG_CODE_LSB 1
`define HCD_CHG_CODE_MSB 3
// status and command fields
`define HCD_STS_CFG_BIT 0
`define HCD_STS_SRST_BIT 1
// reset values
`define HCD_CHG_CODE_RST 3'h0
`define HCD_CHG_RSVD0_RST 1'h0
// delay step of the power re-enable time
`define HCD_DELAY_STEP_MS 200
`define HCD_CLK_HZ 100000000
`define HCD_DELAY_STEP_CYC ((`HCD_DELAY_STEP_MS) * ((`HCD_CLK_HZ) / 1000))
// soft reset restore sequence length in cycles
`define HCD_SRST_CYC 4'h4

`endif

/* File: logic/hcd_pkg.sv */
// hcd_pkg.sv: types shared by the hub config register bank
// assumes: nothing beyond a SystemVerilog compiler
`default_nettype none

package hcd_pkg;
    // power switch sequencer states
    typedef enum logic [1:0] {
        HCD_PWR_ON = 2'b00,
        HCD_PWR_OFF = 2'b01
    } hcd_pwr_state_t;
endpackage

`default_nettype wire

/* File: logic/hcd_delay_timer.sv */
// hcd_delay_timer.sv: power re-enable delay counter
// assumes: start is a one-cycle pulse; code held stable while counting
`default_nettype none
`include "hcd_defines.svh"

module hcd_delay_timer #(
    parameter int STEP_CYC = `HCD_DELAY_STEP_CYC
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic start,
    input wire logic [2:0] code,
    output logic busy,
    output logic done
);
    // ==========================================
    // state
    typedef struct packed {
        logic [31:0] stepCnt; // cycles inside one 200 ms step
        logic [3:0] stepsLeft; // steps still to run
        logic busy;
        logic done;
    } hcd_tmr_t;

    hcd_tmr_t s_q;
    hcd_tmr_t s_d;

    // next state: (code+1) steps of STEP_CYC cycles
    always_comb
    begin
        s_d = s_q;
        s_d.done = 1'b0;
        if (start)
        begin
            s_d.busy = 1'b1;
            s_d.stepsLeft = {1'b0, code} + 4'h1;
            s_d.stepCnt = 32'h0;
        end
        else if (s_q.busy)
        begin
            if (s_q.stepCnt == 32'(STEP_CYC - 1))
            begin
                s_d.stepCnt = 32'h0;
                s_d.stepsLeft = s_q.stepsLeft - 4'h1;
                if (s_q.stepsLeft == 4'h1)
                begin
                    s_d.busy = 1'b0;
                    s_d.done = 1'b1;
                end
            end
            else
            begin
                s_d.stepCnt = s_q.stepCnt + 32'h1;
            end
        end
    end

    // register the state
    always_ff @(posedge clk)
    begin
        if (!rst_n)
            s_q <= '0;
        else
            s_q <= s_d;
    end

    assign busy = s_q.busy;
    assign done = s_q.done;
endmodule // hcd_delay_timer

`default_nettype wire

/* File: logic/hcd_cfg_regs.sv */
// hcd_cfg_regs.sv: charge delay and device status/command registers
// assumes: byte-wide management port, write and read strobes one cycle,
// straps static, eeprom loader presents one byte with a strobe.
`default_nettype none
`include "hcd_defines.svh"

module hcd_cfg_regs #(
    parameter int STEP_CYC = `HCD_DELAY_STEP_CYC
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [7:0] regAddr, // management port byte address
    input wire logic [7:0] regWdata,
    input wire logic regWrite, // one-cycle write strobe
    input wire logic regRead, // one-cycle read strobe
    output logic [7:0] regRdata, // read data, valid cycle after strobe
    input wire logic eepromLoad, // one-cycle eeprom byte strobe
    input wire logic [7:0] eepromAddr,
    input wire logic [7:0] eepromData,
    input wire logic configModeEnter, // pulse: management mode entered
    input wire logic chargeModeChange, // pulse: charging mode transition
    input wire logic [1:0] portPowerRequest, // hub wants power per port
    input wire logic grouped_power_strap,
    input wire logic full_power_mgmt_strap_n,
    input wire logic power_enable_polarity_strap,
    input wire logic charge_enable_strap_port1,
    input wire logic charge_enable_strap_port2,
    output logic port1_power_switch_enable,
    output logic port2_power_switch_enable,
    output logic [1:0] chargeEnable, // per-port charging support
    output logic upstreamConnectAllow,
    output logic individualPowerMode, // per-port switch control
    output logic softResetBusy
);
    // ==========================================
    // state
    typedef struct packed {
        logic [2:0] power_reenable_delay_code;
        logic custom_charge_mode_enable; // reserved bit 0, kept as stored
        logic serial_iface_soft_reset;
        logic config_in_progress_flag;
        logic [3:0] srstCnt;
        hcd_pkg::hcd_pwr_state_t pwrState;
        logic [7:0] rdata;
        logic [1:0] pwrOut;
        logic [1:0] chg;
        logic connOk;
        logic indiv;
    } hcd_regs_t;

    hcd_regs_t s_q;
    hcd_regs_t s_d;

    logic tmrStart;
    logic tmrBusy;
    logic tmrDone;
    logic [1:0] pwrOn;
    logic srstSet; // host write of one to the soft reset bit this cycle

    // ==========================================
    // read mux helper
    function automatic logic [7:0] readReg(input logic [7:0] a, input hcd_regs_t s);
        logic [7:0] r;
        r = 8'h0;
        if (a == `HCD_OFS_CHARGE_CTRL)
            r = {4'h0, s.power_reenable_delay_code, s.custom_charge_mode_enable};
        else if (a == `HCD_OFS_STATUS_CMD)
            r = {6'h0, s.serial_iface_soft_reset, s.config_in_progress_flag};
        return r;
    endfunction

    // ==========================================
    // delay timer
    hcd_delay_timer #(
        .STEP_CYC(STEP_CYC)
    ) u_timer (
        .clk(clk),
        .rst_n(rst_n),
        .start(tmrStart),
        .code(s_q.power_reenable_delay_code),
        .busy(tmrBusy),
        .done(tmrDone)
    );

    // timer starts on a mode change when custom gap is enabled and the sequencer is in HCD_PWR_ON
    // gap only when enable bit set
    assign tmrStart = chargeModeChange && s_q.custom_charge_mode_enable
        && (s_q.pwrState == hcd_pkg::HCD_PWR_ON);

    // soft reset request seen on the management port
    assign srstSet = regWrite && (regAddr == `HCD_OFS_STATUS_CMD) && regWdata[`HCD_STS_SRST_BIT];

    // grouped power follows any request, else per port
    assign pwrOn = (!grouped_power_strap && !full_power_mgmt_strap_n) ? portPowerRequest
        : {2{|portPowerRequest}};

    // ==========================================
    // next state
    always_comb
    begin
        s_d = s_q;
        s_d.rdata = 8'h0;
        // read data registered one cycle after strobe
        if (regRead)
            s_d.rdata = readReg(regAddr, s_q);
        if (eepromLoad && eepromAddr == `HCD_OFS_CHARGE_CTRL)
        begin
            s_d.power_reenable_delay_code = eepromData[`HCD_CHG_CODE_MSB:`HCD_CHG_CODE_LSB];
            s_d.custom_charge_mode_enable = eepromData[`HCD_CHG_RSVD0_BIT];
        end
        // only writable fields change on host write
        if (regWrite && regAddr == `HCD_OFS_CHARGE_CTRL)
        begin
            s_d.power_reenable_delay_code = regWdata[`HCD_CHG_CODE_MSB:`HCD_CHG_CODE_LSB];
            // host expected to keep default here
            s_d.custom_charge_mode_enable = regWdata[`HCD_CHG_RSVD0_BIT];
        end
        else if (regWrite && regAddr == `HCD_OFS_STATUS_CMD)
        begin
            // write one clears the flag, zero ignored
            if (regWdata[`HCD_STS_CFG_BIT])
                s_d.config_in_progress_flag = 1'b0;
            if (regWdata[`HCD_STS_SRST_BIT])
            begin
                s_d.serial_iface_soft_reset = 1'b1;
                s_d.srstCnt = `HCD_SRST_CYC;
            end
        end
        // entering management mode sets the flag, set wins
        if (configModeEnter)
            s_d.config_in_progress_flag = 1'b1;
        // restore sequence while soft reset pending
        if (s_q.serial_iface_soft_reset)
        begin
            s_d.power_reenable_delay_code = `HCD_CHG_CODE_RST;
            s_d.custom_charge_mode_enable = `HCD_CHG_RSVD0_RST;
            // hardware clears bit when done
            // a fresh set write in the same cycle wins and restarts the count
            if (!srstSet)
            begin
                s_d.srstCnt = s_q.srstCnt - 4'h1;
                if (s_q.srstCnt == 4'h1)
                    s_d.serial_iface_soft_reset = 1'b0;
            end
        end
        // power switch sequencer
        case (s_q.pwrState)
            hcd_pkg::HCD_PWR_ON:
            begin
                if (tmrStart)
                    s_d.pwrState = hcd_pkg::HCD_PWR_OFF;
            end
            hcd_pkg::HCD_PWR_OFF:
            begin
                // (code+1) x 200 ms before re-enable
                if (tmrDone)
                    s_d.pwrState = hcd_pkg::HCD_PWR_ON;
            end
            default:
            begin
                s_d.pwrState = hcd_pkg::HCD_PWR_ON;
            end
        endcase
        // polarity strap low gives active high enables
        if (s_d.pwrState == hcd_pkg::HCD_PWR_OFF || tmrBusy)
            s_d.pwrOut = {2{power_enable_polarity_strap}};
        else
            s_d.pwrOut = power_enable_polarity_strap ? ~pwrOn : pwrOn;
        s_d.chg = {charge_enable_strap_port2, charge_enable_strap_port1};
        // no upstream connect while flag set
        s_d.connOk = !s_d.config_in_progress_flag;
        s_d.indiv = !grouped_power_strap && !full_power_mgmt_strap_n;
    end

    // ==========================================
    // register the state
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            s_q <= '0;
        end
        else
        begin
            s_q <= s_d;
        end
    end

    // outputs straight from flops
    assign regRdata = s_q.rdata;
    assign port1_power_switch_enable = s_q.pwrOut[0];
    assign port2_power_switch_enable = s_q.pwrOut[1];
    assign chargeEnable = s_q.chg;
    assign upstreamConnectAllow = s_q.connOk;
    assign individualPowerMode = s_q.indiv;
    assign softResetBusy = s_q.serial_iface_soft_reset;
endmodule // hcd_cfg_regs

`default_nettype wire

/* File: test/hcd_cfg_regs_props.sv */
// checker for the config register bank ports
// assumes: bound into every hcd_cfg_regs instance
`default_nettype none
module hcd_cfg_regs_props #(
    parameter int STEP_CYC = 10
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [7:0] regAddr,
    input wire logic [7:0] regWdata,
    input wire logic regWrite,
    input wire logic regRead,
    input wire logic [7:0] regRdata,
    input wire logic configModeEnter,
    input wire logic chargeModeChange,
    input wire logic [1:0] portPowerRequest,
    input wire logic grouped_power_strap,
    input wire logic full_power_mgmt_strap_n,
    input wire logic power_enable_polarity_strap,
    input wire logic charge_enable_strap_port1,
    input wire logic charge_enable_strap_port2,
    input wire logic port1_power_switch_enable,
    input wire logic [1:0] chargeEnable,
    input wire logic upstreamConnectAllow,
    input wire logic individualPowerMode,
    input wire logic softResetBusy
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    // ========================================
    // properties
    property p_rsvd_chg;
        regRead && regAddr == 8'hf2 |=> regRdata[7:4] == 4'h0;
    endproperty
    a_rsvd_chg: assert property (p_rsvd_chg) else $error("f2 upper bits set");
    property p_rsvd_sts;
        regRead && regAddr == 8'hf8 |=> regRdata[7:2] == 6'h00;
    endproperty
    a_rsvd_sts: assert property (p_rsvd_sts) else $error("f8 upper bits set");
    property p_unmap;
        regRead && regAddr != 8'hf2 && regAddr != 8'hf8 |=> regRdata == 8'h00;
    endproperty
    a_unmap: assert property (p_unmap) else $error("unmapped read not zero");
    property p_cfg_set;
        configModeEnter |-> ##[1:2] !upstreamConnectAllow;
    endproperty
    a_cfg_set: assert property (p_cfg_set) else $error("connect not held off");
    property p_cfg_clr;
        regWrite && regAddr == 8'hf8 && regWdata[0] && !configModeEnter
            |-> ##[1:2] upstreamConnectAllow;
    endproperty
    a_cfg_clr: assert property (p_cfg_clr) else $error("flag not cleared");
    property p_srst;
        regWrite && regAddr == 8'hf8 && regWdata[1] |-> ##[1:2] softResetBusy;
    endproperty
    a_srst: assert property (p_srst) else $error("soft reset not set");
    property p_srst_len;
        $rose(softResetBusy) |-> softResetBusy [*4] ##1 !softResetBusy;
    endproperty
    a_srst_len: assert property (p_srst_len) else $error("soft reset length");
    property p_indiv;
        1'b1 |=> individualPowerMode == $past(!grouped_power_strap && !full_power_mgmt_strap_n);
    endproperty
    a_indiv: assert property (p_indiv) else $error("power mode wrong");
    property p_chg;
        1'b1 |=> chargeEnable == $past({charge_enable_strap_port2, charge_enable_strap_port1});
    endproperty
    a_chg: assert property (p_chg) else $error("charge enable wrong");
    property p_pol;
        port1_power_switch_enable && !power_enable_polarity_strap |-> $past(portPowerRequest[0]);
    endproperty
    a_pol: assert property (p_pol) else $error("enable without request");
    c_cfg: cover property (configModeEnter);
    c_srst: cover property ($rose(softResetBusy));
    c_gap: cover property (chargeModeChange);
endmodule // hcd_cfg_regs_props
bind hcd_cfg_regs hcd_cfg_regs_props #(.STEP_CYC(STEP_CYC)) u_props (.*);
`default_nettype wire

/* File: test/hcd_host_model.sv */
// management host model: byte writes and reads
// assumes: strobes taken at the rising edge after they rise
`default_nettype none
module hcd_host_model (
    input wire logic clk,
    input wire logic [7:0] regRdata,
    output logic [7:0] regAddr,
    output logic [7:0] regWdata,
    output logic regWrite,
    output logic regRead
);
    timeunit 1ns;
    timeprecision 1ns;
    // idle bus at time zero
    initial
    begin
        regAddr = 8'h00;
        regWdata = 8'h00;
        regWrite = 1'b0;
        regRead = 1'b0;
    end
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        regAddr <= a;
        regWdata <= d;
        regWrite <= 1'b1;
        @(posedge clk);
        regWrite <= 1'b0;
        regWdata <= ~d; // released data shows no stale value
    endtask
    // read data stands the cycle after the taking edge
    task automatic rd(input logic [7:0] a, output logic [7:0] v);
        @(posedge clk);
        regAddr <= a;
        regRead <= 1'b1;
        @(posedge clk);
        regRead <= 1'b0;
        #1;
        v = regRdata;
    endtask
endmodule // hcd_host_model
`default_nettype wire

/* File: test/hcd_cfg_regs_tb_top.sv */
// directed bench for the config register bank
// assumes: host model on the management port, straps static
`default_nettype none
`include "hcd_defines.svh"
module hcd_cfg_regs_tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int STEP = 10; // shortened delay step
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic eLoad = 1'b0;
    logic [7:0] eData = 8'h00;
    logic [7:0] eAddr = 8'hf2; // eeprom byte address, moved off 0xf2 once
    logic cfgEnter = 1'b0;
    logic chgChange = 1'b0;
    logic [1:0] pwrReq = 2'b11;
    logic [7:0] regAddr, regWdata, regRdata;
    logic regWrite, regRead, en1, en2, upAllow, indiv, srBusy;
    logic [1:0] chgEn;
    int n_errors = 0;
    int total_checks = 0;
    int cyc = 0;
    always #5 clk = ~clk;
    hcd_host_model u_host (.clk(clk), .regRdata(regRdata), .regAddr(regAddr),
        .regWdata(regWdata), .regWrite(regWrite), .regRead(regRead));
    hcd_cfg_regs #(.STEP_CYC(STEP)) dut (.clk(clk), .rst_n(rst_n), .regAddr(regAddr),
        .regWdata(regWdata), .regWrite(regWrite), .regRead(regRead), .regRdata(regRdata),
        .eepromLoad(eLoad), .eepromAddr(eAddr), .eepromData(eData),
        .configModeEnter(cfgEnter), .chargeModeChange(chgChange), .portPowerRequest(pwrReq),
        .grouped_power_strap(1'b0), .full_power_mgmt_strap_n(1'b0),
        .power_enable_polarity_strap(1'b0), .charge_enable_strap_port1(1'b1),
        .charge_enable_strap_port2(1'b0), .port1_power_switch_enable(en1),
        .port2_power_switch_enable(en2), .chargeEnable(chgEn),
        .upstreamConnectAllow(upAllow), .individualPowerMode(indiv), .softResetBusy(srBusy));
    // compare and count
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        total_checks++;
        if (got !== exp)
        begin
            n_errors++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic wrap_up;
        $display("checks=%0d errors=%0d", total_checks, n_errors);
        if (n_errors == 0 && total_checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    // hang guard
    always @(posedge clk)
    begin
        cyc++;
        if (cyc == 2000)
        begin
            n_errors++;
            wrap_up();
        end
    end
    // main sequence
    initial
    begin
        logic [7:0] v;
        int k;
        repeat (4) @(posedge clk);
        rst_n <= 1'b1;
        u_host.rd(8'hf2, v);
        chk(v, 8'h00);
        u_host.wr(8'hf2, 8'hfe);
        u_host.rd(8'hf2, v);
        chk(v, 8'h0e);
        u_host.wr(8'hf8, 8'hfc);
        u_host.rd(8'hf8, v);
        chk(v, 8'h00);
        u_host.rd(8'h10, v);
        chk(v, 8'h00);
        @(posedge clk);
        eAddr <= 8'h10;
        eLoad <= 1'b1;
        eData <= 8'h07;
        @(posedge clk);
        eLoad <= 1'b0;
        u_host.rd(8'hf2, v);
        chk(v, 8'h0e);
        @(posedge clk);
        eAddr <= 8'hf2;
        eLoad <= 1'b1;
        eData <= 8'h03;
        @(posedge clk);
        eLoad <= 1'b0;
        u_host.rd(8'hf2, v);
        chk(v, 8'h03);
        @(posedge clk);
        cfgEnter <= 1'b1;
        @(posedge clk);
        cfgEnter <= 1'b0;
        u_host.rd(8'hf8, v);
        chk(v, 8'h01);
        chk({7'h0, upAllow}, 8'h00);
        u_host.wr(8'hf8, 8'h00);
        u_host.rd(8'hf8, v);
        chk(v, 8'h01);
        u_host.wr(8'hf8, 8'h01);
        u_host.rd(8'hf8, v);
        chk(v, 8'h00);
        chk({7'h0, upAllow}, 8'h01);
        chk({7'h0, indiv}, 8'h01);
        chk({6'h0, chgEn}, 8'h01);
        chk({6'h0, en2, en1}, 8'h03);
        @(posedge clk);
        chgChange <= 1'b1;
        @(posedge clk);
        chgChange <= 1'b0;
        k = 0;
        repeat (60)
        begin
            @(posedge clk);
            #1;
            if (en1 !== 1'b1)
                k++;
        end
        chk(8'((k >= 2 * STEP && k <= 2 * STEP + 4) ? 1 : 0), 8'h01);
        chk({6'h0, en2, en1}, 8'h03);
        u_host.wr(8'hf2, 8'h0e);
        u_host.wr(8'hf8, 8'h02);
        #1;
        chk({7'h0, srBusy}, 8'h01);
        k = 0;
        while (srBusy === 1'b1 && k < 20)
        begin
            @(posedge clk);
            #1;
            k++;
        end
        chk({7'h0, srBusy}, 8'h00);
        chk(8'(k), 8'(`HCD_SRST_CYC));
        u_host.rd(8'hf2, v);
        chk(v, 8'h00);
        // enable restored to zero: a mode change must not cut power
        @(posedge clk);
        chgChange <= 1'b1;
        @(posedge clk);
        chgChange <= 1'b0;
        k = 0;
        repeat (30)
        begin
            @(posedge clk);
            #1;
            if (en1 !== 1'b1)
                k++;
        end
        chk(8'(k), 8'h00);
        wrap_up();
    end
endmodule // hcd_cfg_regs_tb_top
`default_nettype wire
